// ===== core/p6g_port.sv
/*
 * Eight-pin general purpose port: direction register, output latch,
 * direction-dependent read path and timer function multiplexer,
 * reached as an AHB-Lite slave with zero wait states.
 * Assumes timer control fields and timer outputs come from logic on
 * CLK_IN; pin levels and the hardware standby pin are asynchronous.
 */
`timescale 1ns/1ps

module p6g_port #(
  parameter int unsigned PINS = 8
) (
  input  wire logic                CLK_IN,        // System clock, 200 MHz
  input  wire logic                RST_N_IN,      // Async reset, active low
  input  wire logic                HW_STANDBY_IN, // Hardware standby, async
  input  wire logic                HSEL_IN,       // Slave select
  input  wire logic [31:0]         HADDR_IN,      // Byte address
  input  wire logic [1:0]          HTRANS_IN,     // Transfer type
  input  wire logic                HWRITE_IN,     // Write when high
  input  wire logic [2:0]          HSIZE_IN,      // Transfer size
  input  wire logic [31:0]         HWDATA_IN,     // Write data
  input  wire logic                HREADY_IN,     // Bus ready
  output logic                     HREADYOUT_OUT, // Slave ready
  output logic                     HRESP_OUT,     // Always OKAY
  output logic [31:0]              HRDATA_OUT,    // Read data
  input  wire p6g_pkg::p6g_ctl_s   CTL_IN,        // Timer control fields
  input  wire p6g_pkg::p6g_fn_out_s FN_OUT_IN,    // Timer pin outputs
  output p6g_pkg::p6g_fn_in_s      FN_IN_OUT,     // Pin levels to timers
  input  wire logic [7:0]          PIN_IN,        // Pin levels, async
  output logic [7:0]               PIN_OUT,       // Pin drive value
  output logic [7:0]               PIN_OE_OUT     // Pin driver enable
);
  import p6g_pkg::*;

  // ********************************************************
  // Elaboration check
  // ********************************************************
  if (PINS != PORT_W) begin : g_bad_pins
    $error("p6g_port serves exactly eight pins");
  end

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [7:0]  dir;
    logic [7:0]  latch;
    logic [7:0]  pin_meta;
    logic [7:0]  pin_sync;
    logic        stby_meta;
    logic        stby_sync;
    logic        wr_pend;
    p6g_sel_e    wr_sel;
    logic [31:0] rdata;
    logic [7:0]  pout;
    logic [7:0]  poe;
    p6g_fn_in_s  fin;
  } p6g_state_s;

  p6g_state_s st_r;
  p6g_state_s st_nxt;

  function automatic logic os_active(input logic [3:0] os);
    return os != OS_NONE;
  endfunction

  // Codes at and above the first external code pick an external clock
  function automatic logic tmr_ext(input logic [2:0] cks);
    return cks >= TMR_CKS_EXT;
  endfunction

  function automatic p6g_sel_e decode(input logic [31:0] a);
    if (a == DIR_ADDR) begin
      return SEL_DIR;
    end else if (a == LATCH_ADDR) begin
      return SEL_LATCH;
    end
    return SEL_NONE;
  endfunction

  // ********************************************************
  // Next state
  // ********************************************************
  logic       take;
  p6g_sel_e   rd_sel;
  logic [7:0] port_val;
  logic [7:0] fsel;
  logic [7:0] fval;

  always_comb begin
    st_nxt           = st_r;
    // Pin and standby inputs pass two flops before any use
    st_nxt.pin_meta  = PIN_IN;
    st_nxt.pin_sync  = st_r.pin_meta;
    st_nxt.stby_meta = HW_STANDBY_IN;
    st_nxt.stby_sync = st_r.stby_meta;

    take   = HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NSEQ ||
             HTRANS_IN == HTRANS_SEQ);
    rd_sel = decode(HADDR_IN);

    // Data phase of a write lands here
    if (st_r.wr_pend) begin
      case (st_r.wr_sel)
        SEL_DIR: begin
          st_nxt.dir = HWDATA_IN[7:0];
        end
        SEL_LATCH: begin
          st_nxt.latch = HWDATA_IN[7:0];
        end
        default: begin
        end
      endcase
    end
    if (st_r.stby_sync) begin
      st_nxt.dir   = DIR_RST;
      st_nxt.latch = LATCH_RST;
    end

    st_nxt.wr_pend = take && HWRITE_IN;
    st_nxt.wr_sel  = take ? rd_sel : SEL_NONE;

    // Read uses post-write values so a back-to-back read sees the write
    port_val = (st_nxt.dir & st_nxt.latch) |
               (~st_nxt.dir & st_r.pin_sync);
    if (take && !HWRITE_IN) begin
      case (rd_sel)
        SEL_LATCH: begin
          st_nxt.rdata = {24'h00_0000, port_val};
        end
        SEL_DIR: begin
          st_nxt.rdata = RDATA_NONE;
        end
        default: begin
          st_nxt.rdata = RDATA_NONE;
        end
      endcase
    end

    // Output function priority per pin
    fsel    = 8'h00;
    fval    = 8'h00;
    fsel[7] = 1'b1;
    if (CTL_IN.hsync_out_enable) begin
      fval[7] = FN_OUT_IN.horizontal_sync_output;
    end else if (os_active(CTL_IN.extra_byte_timer_timer_output_select)) begin
      fval[7] = FN_OUT_IN.extra_timer_output;
    end else if (os_active(CTL_IN.byte_timer_one_timer_output_select)) begin
      fval[7] = FN_OUT_IN.timer_one_output;
    end else begin
      fsel[7] = 1'b0;
    end
    fsel[6] = CTL_IN.frt_compare_b_out_enable;
    fval[6] = FN_OUT_IN.frt_compare_b_output;
    fsel[4] = 1'b1;
    if (CTL_IN.clamp_out_enable) begin
      fval[4] = FN_OUT_IN.clamp_pulse_output;
    end else if (os_active(CTL_IN.byte_timer_zero_timer_output_select)) begin
      fval[4] = FN_OUT_IN.timer_zero_output;
    end else begin
      fsel[4] = 1'b0;
    end
    // Both enables set is a software fault; vsync still wins
    fsel[1] = 1'b1;
    if (CTL_IN.vsync_out_enable) begin
      fval[1] = FN_OUT_IN.vertical_sync_output;
    end else if (CTL_IN.frt_compare_a_out_enable) begin
      fval[1] = FN_OUT_IN.frt_compare_a_output;
    end else begin
      fsel[1] = 1'b0;
    end
    // Pins 5, 3, 2 and 0 have no output function
    st_nxt.pout = (fsel & fval) | (~fsel & st_nxt.latch);
    st_nxt.poe  = fsel | st_nxt.dir;

    // Input routing; pins keep feeding timers whatever drives them
    st_nxt.fin.compare_input = st_r.pin_sync;
    st_nxt.fin.timer_one_reset_input = st_r.pin_sync[6] &
      CTL_IN.byte_timer_one_counter_clear_select_hi & CTL_IN.byte_timer_one_counter_clear_select_lo;
    st_nxt.fin.composite_sync_input  = st_r.pin_sync[6];
    st_nxt.fin.timer_one_clock_input = st_r.pin_sync[5] &
      tmr_ext(CTL_IN.byte_timer_one_timer_clock_select);
    st_nxt.fin.frt_capture_d_input   = st_r.pin_sync[5];
    st_nxt.fin.horizontal_sync_input = st_r.pin_sync[5];
    st_nxt.fin.frt_capture_c_input   = st_r.pin_sync[4];
    st_nxt.fin.timer_zero_reset_input = st_r.pin_sync[3] &
      CTL_IN.byte_timer_zero_counter_clear_select_hi & CTL_IN.byte_timer_zero_counter_clear_select_lo;
    st_nxt.fin.frt_capture_b_input     = st_r.pin_sync[3];
    st_nxt.fin.vertical_feedback_input = st_r.pin_sync[3];
    st_nxt.fin.frt_capture_a_input      = st_r.pin_sync[2];
    st_nxt.fin.second_extra_timer_input = st_r.pin_sync[2];
    st_nxt.fin.vertical_sync_input      = st_r.pin_sync[2];
    st_nxt.fin.frt_clock_input = st_r.pin_sync[0] &
      (CTL_IN.frt_timer_clock_select == FRT_CKS_EXT);
    st_nxt.fin.timer_zero_clock_input = st_r.pin_sync[0] &
      tmr_ext(CTL_IN.byte_timer_zero_timer_clock_select);
    st_nxt.fin.extra_timer_input         = st_r.pin_sync[0];
    st_nxt.fin.horizontal_feedback_input = st_r.pin_sync[0];
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r        <= '0;
      st_r.dir    <= DIR_RST;
      st_r.latch  <= LATCH_RST;
      st_r.wr_sel <= SEL_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = HRESP_OKAY;
  assign HRDATA_OUT    = st_r.rdata;
  assign PIN_OUT       = st_r.pout;
  assign PIN_OE_OUT    = st_r.poe;
  assign FN_IN_OUT     = st_r.fin;

endmodule

// ===== core/p6g_pkg.sv
/*
 * Constants, field layouts and carrier structs for the eight-pin port
 * with its timer pin multiplexer.
 * Assumes one system clock; timer control fields arrive from the timer
 * blocks on that same clock.
 */
package p6g_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam int unsigned   PORT_W       = 8;
  // Printed offsets are indices; byte address is four times the index
  localparam logic [15:0]   DIR_IDX      = 16'hFFB9;
  localparam logic [15:0]   LATCH_IDX    = 16'hFFBB;
  localparam logic [31:0]   DIR_ADDR     = {16'h0000, DIR_IDX} << 2;
  localparam logic [31:0]   LATCH_ADDR   = {16'h0000, LATCH_IDX} << 2;
  localparam logic [7:0]    DIR_RST      = 8'h00;
  localparam logic [7:0]    LATCH_RST    = 8'h00;
  localparam logic [31:0]   RDATA_NONE   = 32'h0000_0000;

  // ********************************************************
  // Bus encodings, clock-select and output-select codes
  // ********************************************************
  localparam logic [1:0]    HTRANS_NSEQ  = 2'h2;
  localparam logic [1:0]    HTRANS_SEQ   = 2'h3;
  localparam logic          HRESP_OKAY   = 1'b0;
  localparam logic [1:0]    FRT_CKS_EXT  = 2'h3;
  localparam logic [2:0]    TMR_CKS_EXT  = 3'h5;
  localparam logic [3:0]    OS_NONE      = 4'h0;

  // ********************************************************
  // Carriers
  // ********************************************************
  typedef enum logic [2:0] {
    SEL_NONE  = 3'b001,
    SEL_DIR   = 3'b010,
    SEL_LATCH = 3'b100
  } p6g_sel_e;

  typedef struct packed {
    logic       hsync_out_enable;
    logic       clamp_out_enable;
    logic       vsync_out_enable;
    logic       frt_compare_a_out_enable;
    logic       frt_compare_b_out_enable;
    logic [3:0] byte_timer_one_timer_output_select;
    logic [3:0] extra_byte_timer_timer_output_select;
    logic [3:0] byte_timer_zero_timer_output_select;
    logic       byte_timer_one_counter_clear_select_hi;
    logic       byte_timer_one_counter_clear_select_lo;
    logic       byte_timer_zero_counter_clear_select_hi;
    logic       byte_timer_zero_counter_clear_select_lo;
    logic [2:0] byte_timer_one_timer_clock_select;
    logic [2:0] byte_timer_zero_timer_clock_select;
    logic [1:0] frt_timer_clock_select;
  } p6g_ctl_s;

  typedef struct packed {
    logic horizontal_sync_output;
    logic extra_timer_output;
    logic timer_one_output;
    logic frt_compare_b_output;
    logic clamp_pulse_output;
    logic timer_zero_output;
    logic vertical_sync_output;
    logic frt_compare_a_output;
  } p6g_fn_out_s;

  typedef struct packed {
    logic [7:0] compare_input;
    logic       timer_one_reset_input;
    logic       composite_sync_input;
    logic       frt_capture_d_input;
    logic       timer_one_clock_input;
    logic       horizontal_sync_input;
    logic       frt_capture_c_input;
    logic       frt_capture_b_input;
    logic       timer_zero_reset_input;
    logic       vertical_feedback_input;
    logic       frt_capture_a_input;
    logic       vertical_sync_input;
    logic       second_extra_timer_input;
    logic       frt_clock_input;
    logic       timer_zero_clock_input;
    logic       horizontal_feedback_input;
    logic       extra_timer_input;
  } p6g_fn_in_s;

endpackage

// ===== sim/p6g_board.sv
/*
 Board model for the eight port pins: the port wins where it drives,
 the board level shows elsewhere. Assumes no pull resistors.
*/
`timescale 1ns/1ps
module p6g_board (
  input  wire logic [7:0] drv_in,  // Port drive value
  input  wire logic [7:0] oe_in,   // Port driver enable
  input  wire logic [7:0] ext_in,  // Board level
  output logic [7:0]      pin_out  // Resolved pin level
);
  assign pin_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule

// ===== sim/p6g_port_checker.sv
/*
 Assertions on the port block pins, routing and read path.
 Assumes one clock domain; bound to p6g_port below.
*/
`timescale 1ns/1ps
module p6g_port_checker
  import p6g_pkg::*;
(
  input wire logic        CLK_IN,        // Clock
  input wire logic        RST_N_IN,      // Reset
  input wire logic        HW_STANDBY_IN, // Standby
  input wire logic        HSEL_IN,       // Select
  input wire logic [31:0] HADDR_IN,      // Address
  input wire logic [1:0]  HTRANS_IN,     // Transfer
  input wire logic        HWRITE_IN,     // Write
  input wire logic        HREADY_IN,     // Ready
  input wire logic [31:0] HRDATA_OUT,    // Read data
  input wire p6g_ctl_s    CTL_IN,        // Controls
  input wire p6g_fn_out_s FN_OUT_IN,     // Timer outputs
  input wire p6g_fn_in_s  FN_IN_OUT,     // Timer inputs
  input wire logic [7:0]  PIN_IN,        // Pin levels
  input wire logic [7:0]  PIN_OUT,       // Pin drive
  input wire logic [7:0]  PIN_OE_OUT     // Pin enable
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Counts edges since reset so $past never looks into reset
  logic [2:0] up_r;
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  property p_hsync;
    CTL_IN.hsync_out_enable |=> PIN_OE_OUT[7] && PIN_OUT[7] == $past(FN_OUT_IN.horizontal_sync_output);
  endproperty
  a_hsync: assert property (p_hsync) else $error("pin 7 not hsync");
  property p_cmpb;
    CTL_IN.frt_compare_b_out_enable |=> PIN_OE_OUT[6] && PIN_OUT[6] == $past(FN_OUT_IN.frt_compare_b_output);
  endproperty
  a_cmpb: assert property (p_cmpb) else $error("pin 6 not compare B");
  property p_clamp;
    CTL_IN.clamp_out_enable |=> PIN_OE_OUT[4] && PIN_OUT[4] == $past(FN_OUT_IN.clamp_pulse_output);
  endproperty
  a_clamp: assert property (p_clamp) else $error("pin 4 not clamp");
  property p_vsync;
    CTL_IN.vsync_out_enable |=> PIN_OE_OUT[1] && PIN_OUT[1] == $past(FN_OUT_IN.vertical_sync_output);
  endproperty
  a_vsync: assert property (p_vsync) else $error("pin 1 not vsync");
  property p_cmpa;
    !CTL_IN.vsync_out_enable && CTL_IN.frt_compare_a_out_enable
      |=> PIN_OE_OUT[1] && PIN_OUT[1] == $past(FN_OUT_IN.frt_compare_a_output);
  endproperty
  a_cmpa: assert property (p_cmpa) else $error("pin 1 not compare A");
  property p_stby;
    (HW_STANDBY_IN && CTL_IN == '0)[*5] |=> PIN_OE_OUT == DIR_RST;
  endproperty
  a_stby: assert property (p_stby) else $error("standby left a driver on");
  property p_t0rst;
    (!CTL_IN.byte_timer_zero_counter_clear_select_hi)[*4] |-> !FN_IN_OUT.timer_zero_reset_input;
  endproperty
  a_t0rst: assert property (p_t0rst) else $error("timer zero reset routed");
  property p_t1clk;
    (CTL_IN.byte_timer_one_timer_clock_select < TMR_CKS_EXT)[*4] |-> !FN_IN_OUT.timer_one_clock_input;
  endproperty
  a_t1clk: assert property (p_t1clk) else $error("timer one clock routed");
  property p_always;
    up_r >= 3'h4 |-> FN_IN_OUT.compare_input == $past(PIN_IN, 3)
      && FN_IN_OUT.frt_capture_c_input == $past(PIN_IN[4], 3);
  endproperty
  a_always: assert property (p_always) else $error("compare inputs lag pins");
  property p_dirrd;
    HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN && HADDR_IN == DIR_ADDR
      |=> HRDATA_OUT == RDATA_NONE;
  endproperty
  a_dirrd: assert property (p_dirrd) else $error("direction readable");
endmodule

bind p6g_port p6g_port_checker p6g_port_checker_i (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .HW_STANDBY_IN(HW_STANDBY_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
  .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
  .HRDATA_OUT(HRDATA_OUT), .CTL_IN(CTL_IN), .FN_OUT_IN(FN_OUT_IN), .FN_IN_OUT(FN_IN_OUT),
  .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT));

// ===== sim/p6g_port_tb.sv
/*
 Self-checking bench for p6g_port: random controls, data and board
 levels over AHB-Lite, then hardware standby. Assumes the board model.
*/
`timescale 1ns/1ps
module p6g_port_tb;
  import p6g_pkg::*;
  logic        clk = 0, rst_n = 0, stby = 0, hsel = 0, hwrite = 0, rdy, resp;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [7:0]  board = 0, pin, pin_o, pin_oe, d, l, pe;
  logic [15:0] x;
  p6g_ctl_s    ctl = '0, c;
  p6g_fn_out_s fo = '0;
  p6g_fn_in_s  fi;
  int          seed = 32'h0000_a26b, mismatches = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  p6g_port p6g_port_i (.CLK_IN(clk), .RST_N_IN(rst_n), .HW_STANDBY_IN(stby), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(rdy), .HREADYOUT_OUT(rdy), .HRESP_OUT(resp),
    .HRDATA_OUT(hrdata), .CTL_IN(ctl), .FN_OUT_IN(fo), .FN_IN_OUT(fi), .PIN_IN(pin),
    .PIN_OUT(pin_o), .PIN_OE_OUT(pin_oe));
  p6g_board p6g_board_i (.drv_in(pin_o), .oe_in(pin_oe), .ext_in(board), .pin_out(pin));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Holds each phase until ready is seen high at an edge
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NSEQ;
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (rdy !== 1'b1);
    r = hrdata;
    // Ready and response levels are seen at the same edge as the data
    chk("resp", {31'h0000_0000, rdy, resp}, {31'h0000_0000, 1'b1, HRESP_OKAY});
  endtask
  function automatic logic [15:0] drv(p6g_ctl_s c, p6g_fn_out_s f, logic [7:0] d, l);
    logic [7:0] e, o;
    logic xs, t1, t0;
    xs = |c.extra_byte_timer_timer_output_select;
    t1 = |c.byte_timer_one_timer_output_select;
    t0 = |c.byte_timer_zero_timer_output_select;
    e = d | {c.hsync_out_enable | xs | t1, c.frt_compare_b_out_enable, 1'b0,
      c.clamp_out_enable | t0, 2'b00, c.vsync_out_enable | c.frt_compare_a_out_enable, 1'b0};
    o = l;
    o[7] = c.hsync_out_enable ? f.horizontal_sync_output : xs ? f.extra_timer_output
      : t1 ? f.timer_one_output : l[7];
    o[6] = c.frt_compare_b_out_enable ? f.frt_compare_b_output : l[6];
    o[4] = c.clamp_out_enable ? f.clamp_pulse_output : t0 ? f.timer_zero_output : l[4];
    o[1] = c.vsync_out_enable ? f.vertical_sync_output
      : c.frt_compare_a_out_enable ? f.frt_compare_a_output : l[1];
    return {e, o};
  endfunction
  function automatic p6g_fn_in_s fexp(p6g_ctl_s c, logic [7:0] p);
    return {p, c.byte_timer_one_counter_clear_select_hi & c.byte_timer_one_counter_clear_select_lo & p[6], p[6],
      p[5], (c.byte_timer_one_timer_clock_select >= TMR_CKS_EXT) & p[5], p[5], p[4], p[3],
      c.byte_timer_zero_counter_clear_select_hi & c.byte_timer_zero_counter_clear_select_lo & p[3], p[3], p[2],
      p[2], p[2], (c.frt_timer_clock_select == FRT_CKS_EXT) & p[0],
      (c.byte_timer_zero_timer_clock_select >= TMR_CKS_EXT) & p[0], p[0], p[0]};
  endfunction
  task close_out;
    $display("Compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, LATCH_ADDR, 32'h0000_0000, rd);
    chk("latch_rst", rd, {24'h0, LATCH_RST});
    chk("oe_rst", pin_oe, DIR_RST);
    $display("test reset done");
    for (int i = 0; i < 48; i++) begin
      c = 29'($random(seed) & $random(seed));
      if (c.vsync_out_enable) c.frt_compare_a_out_enable = 1'b0;
      d = 8'($random(seed));
      l = 8'($random(seed));
      // First passes: all inputs, then all outputs against an opposing board
      if (i < 2) c = '0;
      if (i < 2) d = {8{i[0]}};
      ctl <= c;
      fo <= 8'($random(seed));
      board <= (i < 2) ? ~l : 8'($random(seed));
      bus(1'b1, DIR_ADDR, {24'h0, d}, rd);
      bus(1'b1, LATCH_ADDR, {24'h0, l}, rd);
      repeat (6) @(posedge clk);
      x = drv(c, fo, d, l);
      pe = (x[15:8] & x[7:0]) | (~x[15:8] & board);
      chk("oe", pin_oe, x[15:8]);
      chk("out", pin_o & x[15:8], x[7:0] & x[15:8]);
      chk("fn_in", fi, fexp(c, pe));
      bus(1'b0, LATCH_ADDR, 32'h0000_0000, rd);
      chk("read", rd, {24'h0, (d & l) | (~d & pe)});
      bus(1'b0, DIR_ADDR, 32'h0000_0000, rd);
      chk("dir_read", rd, RDATA_NONE);
    end
    bus(1'b1, DIR_ADDR, 32'h0000_00ff, rd);
    bus(1'b1, LATCH_ADDR + 32'h0000_0004, 32'h0000_005a, rd);
    bus(1'b0, LATCH_ADDR, 32'h0000_0000, rd);
    chk("unmapped", rd, {24'h0, l});
    $display("test random done");
    ctl <= '0;
    stby <= 1'b1;
    repeat (6) @(posedge clk);
    stby <= 1'b0;
    repeat (3) @(posedge clk);
    chk("oe_stby", pin_oe, DIR_RST);
    bus(1'b1, DIR_ADDR, 32'h0000_00ff, rd);
    bus(1'b0, LATCH_ADDR, 32'h0000_0000, rd);
    chk("latch_stby", rd, {24'h0, LATCH_RST});
    $display("test standby done");
    close_out();
  end
endmodule
